// >>> rtl/oag_pkg.sv
// Behaviour
// - mode 0: workspace register is the operand
// - mode 1: register contents give operand address
// - mode 2: fetch one extension word per operand
// - mode 2, register 0: extension word is address
// - mode 2, register n: register plus extension word
// - register zero never serves as index register
// - mode 3: use register, then add step back
// - jump target: address plus two plus twice displacement
// - jump targets always land on even addresses
// - io base is bits 12..1 of register 12
// - io bit address: base plus sign-extended displacement
// - set_io_bit_one drives one to the bit
// - set_io_bit_zero drives zero to the bit
// - byte indicator 1 selects byte, 0 word
`default_nettype none
package oag_pkg;
    localparam int unsigned OAG_AW = 6;
    localparam logic [5:0] OFS_CTRL = 6'h00;
    localparam logic [5:0] OFS_STATUS = 6'h04;
    localparam logic [5:0] OFS_INSTR = 6'h08;
    localparam logic [5:0] OFS_KIND = 6'h0c;
    localparam logic [5:0] OFS_WP = 6'h10;
    localparam logic [5:0] OFS_PC = 6'h14;
    localparam logic [5:0] OFS_SRC_EA = 6'h18;
    localparam logic [5:0] OFS_DST_EA = 6'h1c;
    localparam logic [5:0] OFS_TARGET = 6'h20;
    localparam logic [5:0] OFS_IO_ADDR = 6'h24;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [2:0] RST_KIND = 3'h0;
    localparam logic [11:0] RST_IO_ADDR = 12'h000;
    // field positions of the instruction word and the control register, bit 0 is the least significant
    localparam int unsigned POS_BYTE = 12;
    localparam int unsigned POS_TD = 10;
    localparam int unsigned POS_D = 6;
    localparam int unsigned POS_TS = 4;
    localparam int unsigned POS_S = 0;
    localparam int unsigned POS_CTRL_START = 0;
    localparam logic [1:0] MODE_REG = 2'h0;
    localparam logic [1:0] MODE_IND = 2'h1;
    localparam logic [1:0] MODE_MEM = 2'h2;
    localparam logic [1:0] MODE_AUTO = 2'h3;
    localparam logic [2:0] KIND_TWO = 3'h0;
    localparam logic [2:0] KIND_ONE = 3'h1;
    localparam logic [2:0] KIND_JUMP = 3'h2;
    localparam logic [2:0] KIND_BIT_ONE = 3'h3;
    localparam logic [2:0] KIND_BIT_ZERO = 3'h4;
    localparam logic [3:0] IO_BASE_REG = 4'hc;
    localparam logic [3:0] REG_ZERO = 4'h0;
    localparam logic [15:0] STEP_BYTE = 16'h0001;
    localparam logic [15:0] STEP_WORD = 16'h0002;
    localparam logic [15:0] WORD_BYTES = 16'h0002;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_DECODE = 4'b0001,
        ST_FETCH_EXT = 4'b0010,
        ST_READ_REG = 4'b0011,
        ST_WRITE_REG = 4'b0100,
        ST_NEXT = 4'b0101,
        ST_READ_IOBASE = 4'b0110,
        ST_IO_DRIVE = 4'b0111
    } oag_state_t;

    // memory word address of workspace register n
    function automatic logic [15:0] oag_reg_addr(input logic [15:0] wp, input logic [3:0] n);
        oag_reg_addr = wp + {11'h000, n, 1'b0};
    endfunction : oag_reg_addr

    function automatic logic [15:0] oag_sext8(input logic [7:0] d);
        oag_sext8 = {{8{d[7]}}, d};
    endfunction : oag_sext8
endpackage : oag_pkg
`default_nettype wire

// >>> rtl/oag_field_decode.sv
`timescale 1ns/10ps
`default_nettype none
module oag_field_decode (
    input wire logic [15:0] instr,
    input wire logic use_dst,
    output logic [1:0] op_mode,
    output logic [3:0] op_reg,
    output logic [15:0] step
);
    import oag_pkg::*;

    always_comb begin
        op_mode = use_dst ? instr[POS_TD +: 2] : instr[POS_TS +: 2];
        op_reg = use_dst ? instr[POS_D +: 4] : instr[POS_S +: 4];
        step = instr[POS_BYTE] ? STEP_BYTE : STEP_WORD;
    end
endmodule : oag_field_decode
`default_nettype wire

// >>> rtl/oag_addr_calc.sv
`timescale 1ns/10ps
`default_nettype none
module oag_addr_calc (
    input wire logic [15:0] pc,
    input wire logic [7:0] disp,
    input wire logic [15:0] iobase_word,
    output logic [15:0] jump_target,
    output logic [11:0] io_bit_addr
);
    import oag_pkg::*;

    logic [15:0] sum;
    logic [15:0] disp_ext;

    always_comb begin
        disp_ext = oag_sext8(disp);
        sum = pc + WORD_BYTES + {disp_ext[14:0], 1'b0};
        jump_target = {sum[15:1], 1'b0};
        io_bit_addr = iobase_word[12:1] + disp_ext[11:0];
    end
endmodule : oag_addr_calc
`default_nettype wire

// >>> rtl/oag_operand_address_generator.sv
// Design decisions made here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module oag_operand_address_generator (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [oag_pkg::OAG_AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic mem_req,
    output logic mem_we,
    output logic [15:0] mem_addr,
    output logic [15:0] mem_wdata,
    input wire logic [15:0] mem_rdata,
    input wire logic mem_ack,
    output logic [11:0] io_addr,
    output logic io_bit,
    output logic io_write
);
    import oag_pkg::*;

    oag_state_t state, next_state;
    logic [15:0] wp, next_wp, pc, next_pc, instr, next_instr;
    logic [2:0] kind, next_kind;
    logic [15:0] cur_ea, next_cur_ea, ext, next_ext, ext_ptr, next_ext_ptr;
    logic [15:0] src_ea, next_src_ea, dst_ea, next_dst_ea, target, next_target;
    logic cur_dst, next_cur_dst, cur_is_reg, next_cur_is_reg;
    logic src_is_reg, next_src_is_reg, dst_is_reg, next_dst_is_reg;
    logic done, next_done;
    logic next_mem_req, next_mem_we, next_io_bit, next_io_write;
    logic [15:0] next_mem_addr, next_mem_wdata;
    logic [11:0] next_io_addr;
    logic [31:0] next_readdata;
    logic next_waitrequest;
    logic [1:0] op_mode;
    logic [3:0] op_reg;
    logic [15:0] step, jump_target;
    logic [11:0] io_bit_addr;
    logic bus_req, bus_wr_done, idle, start;

    oag_field_decode u_decode (
        .instr(instr),
        .use_dst(cur_dst),
        .op_mode(op_mode),
        .op_reg(op_reg),
        .step(step)
    );

    oag_addr_calc u_calc (
        .pc(pc),
        .disp(instr[7:0]),
        .iobase_word(mem_rdata),
        .jump_target(jump_target),
        .io_bit_addr(io_bit_addr)
    );

    // register bus: one wait cycle, then the answer stands for one cycle
    always_comb begin
        idle = (state == ST_IDLE);
        bus_req = avs_read | avs_write;
        bus_wr_done = avs_write & ~avs_waitrequest;
        start = bus_wr_done & idle & (avs_address == OFS_CTRL) & avs_writedata[POS_CTRL_START];
        next_waitrequest = ~(bus_req & avs_waitrequest);
        next_wp = wp;
        next_pc = pc;
        next_instr = instr;
        next_kind = kind;
        if (bus_wr_done && idle) begin
            unique case (avs_address)
                OFS_INSTR: next_instr = avs_writedata[15:0];
                OFS_KIND: next_kind = avs_writedata[2:0];
                OFS_WP: next_wp = avs_writedata[15:0];
                OFS_PC: next_pc = avs_writedata[15:0];
                default: next_wp = wp;
            endcase
        end
        next_readdata = 32'h0000_0000;
        if (bus_req && avs_waitrequest) begin
            unique case (avs_address)
                OFS_STATUS: next_readdata = {28'h000_0000, dst_is_reg, src_is_reg, done, ~idle};
                OFS_INSTR: next_readdata = {16'h0000, instr};
                OFS_KIND: next_readdata = {29'h0000_0000, kind};
                OFS_WP: next_readdata = {16'h0000, wp};
                OFS_PC: next_readdata = {16'h0000, pc};
                OFS_SRC_EA: next_readdata = {16'h0000, src_ea};
                OFS_DST_EA: next_readdata = {16'h0000, dst_ea};
                OFS_TARGET: next_readdata = {16'h0000, target};
                OFS_IO_ADDR: next_readdata = {20'h0_0000, io_addr};
                default: next_readdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
            wp <= RST_WORD;
            pc <= RST_WORD;
            instr <= RST_WORD;
            kind <= RST_KIND;
        end else begin
            avs_waitrequest <= next_waitrequest;
            avs_readdata <= next_readdata;
            wp <= next_wp;
            pc <= next_pc;
            instr <= next_instr;
            kind <= next_kind;
        end
    end

    // operand sequencer
    always_comb begin
        next_state = state;
        next_cur_dst = cur_dst;
        next_cur_ea = cur_ea;
        next_cur_is_reg = cur_is_reg;
        next_ext = ext;
        next_ext_ptr = ext_ptr;
        next_src_ea = src_ea;
        next_src_is_reg = src_is_reg;
        next_dst_ea = dst_ea;
        next_dst_is_reg = dst_is_reg;
        next_target = target;
        next_done = done;
        next_mem_req = 1'b0;
        next_mem_we = 1'b0;
        next_mem_addr = mem_addr;
        next_mem_wdata = mem_wdata;
        next_io_addr = io_addr;
        next_io_bit = io_bit;
        next_io_write = 1'b0;
        unique case (state)
            ST_IDLE: begin
                if (start) begin
                    next_done = 1'b0;
                    next_cur_dst = 1'b0;
                    next_ext_ptr = pc + WORD_BYTES;
                    next_state = ST_DECODE;
                end
            end
            ST_DECODE: begin
                next_cur_is_reg = 1'b0;
                if (kind == KIND_JUMP) begin
                    next_target = jump_target;
                    next_done = 1'b1;
                    next_state = ST_IDLE;
                end else if (kind == KIND_BIT_ONE || kind == KIND_BIT_ZERO) begin
                    next_mem_req = 1'b1;
                    next_mem_addr = oag_reg_addr(wp, IO_BASE_REG);
                    next_state = ST_READ_IOBASE;
                end else if (op_mode == MODE_REG) begin
                    next_cur_ea = oag_reg_addr(wp, op_reg);
                    next_cur_is_reg = 1'b1;
                    next_state = ST_NEXT;
                end else if (op_mode == MODE_MEM) begin
                    next_mem_req = 1'b1;
                    next_mem_addr = ext_ptr;
                    next_state = ST_FETCH_EXT;
                end else begin
                    next_mem_req = 1'b1;
                    next_mem_addr = oag_reg_addr(wp, op_reg);
                    next_state = ST_READ_REG;
                end
            end
            ST_FETCH_EXT: begin
                next_mem_req = ~mem_ack;
                if (mem_ack) begin
                    next_ext = mem_rdata;
                    next_ext_ptr = ext_ptr + WORD_BYTES;
                    if (op_reg == REG_ZERO) begin
                        next_cur_ea = mem_rdata;
                        next_state = ST_NEXT;
                    end else begin
                        next_mem_req = 1'b1;
                        next_mem_addr = oag_reg_addr(wp, op_reg);
                        next_state = ST_READ_REG;
                    end
                end
            end
            ST_READ_REG: begin
                next_mem_req = ~mem_ack;
                if (mem_ack) begin
                    next_state = ST_NEXT;
                    if (op_mode == MODE_MEM) begin
                        next_cur_ea = mem_rdata + ext;
                    end else if (op_mode == MODE_AUTO) begin
                        next_cur_ea = mem_rdata;
                        next_mem_req = 1'b1;
                        next_mem_we = 1'b1;
                        next_mem_wdata = mem_rdata + step;
                        next_state = ST_WRITE_REG;
                    end else begin
                        next_cur_ea = mem_rdata;
                    end
                end
            end
            ST_WRITE_REG: begin
                next_mem_req = ~mem_ack;
                next_mem_we = ~mem_ack;
                if (mem_ack) begin
                    next_state = ST_NEXT;
                end
            end
            ST_NEXT: begin
                if (cur_dst) begin
                    next_dst_ea = cur_ea;
                    next_dst_is_reg = cur_is_reg;
                end else begin
                    next_src_ea = cur_ea;
                    next_src_is_reg = cur_is_reg;
                end
                if (kind == KIND_TWO && !cur_dst) begin
                    next_cur_dst = 1'b1;
                    next_state = ST_DECODE;
                end else begin
                    next_done = 1'b1;
                    next_state = ST_IDLE;
                end
            end
            ST_READ_IOBASE: begin
                next_mem_req = ~mem_ack;
                if (mem_ack) begin
                    next_io_addr = io_bit_addr;
                    next_state = ST_IO_DRIVE;
                end
            end
            ST_IO_DRIVE: begin
                next_io_write = 1'b1;
                next_io_bit = (kind == KIND_BIT_ONE);
                next_done = 1'b1;
                next_state = ST_IDLE;
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= ST_IDLE;
            cur_dst <= 1'b0;
            cur_ea <= RST_WORD;
            cur_is_reg <= 1'b0;
            ext <= RST_WORD;
            ext_ptr <= RST_WORD;
            src_ea <= RST_WORD;
            src_is_reg <= 1'b0;
            dst_ea <= RST_WORD;
            dst_is_reg <= 1'b0;
            target <= RST_WORD;
            done <= 1'b0;
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= RST_WORD;
            mem_wdata <= RST_WORD;
            io_addr <= RST_IO_ADDR;
            io_bit <= 1'b0;
            io_write <= 1'b0;
        end else begin
            state <= next_state;
            cur_dst <= next_cur_dst;
            cur_ea <= next_cur_ea;
            cur_is_reg <= next_cur_is_reg;
            ext <= next_ext;
            ext_ptr <= next_ext_ptr;
            src_ea <= next_src_ea;
            src_is_reg <= next_src_is_reg;
            dst_ea <= next_dst_ea;
            dst_is_reg <= next_dst_is_reg;
            target <= next_target;
            done <= next_done;
            mem_req <= next_mem_req;
            mem_we <= next_mem_we;
            mem_addr <= next_mem_addr;
            mem_wdata <= next_mem_wdata;
            io_addr <= next_io_addr;
            io_bit <= next_io_bit;
            io_write <= next_io_write;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    logic is_gen;
    logic [15:0] disp_sext;
    assign is_gen = (kind == KIND_TWO || kind == KIND_ONE);
    assign disp_sext = oag_sext8(instr[7:0]);

    sequence reg_read_done_s;
        state == ST_READ_REG && mem_ack;
    endsequence

    reg_operand_a: assert property (state == ST_DECODE && is_gen && op_mode == MODE_REG
        |=> state == ST_NEXT && cur_is_reg && cur_ea == $past(wp) + {11'h000, $past(op_reg), 1'b0})
        else $error("register operand address wrong");
    indirect_ea_a: assert property ((reg_read_done_s and op_mode == MODE_IND)
        |=> state == ST_NEXT && cur_ea == $past(mem_rdata))
        else $error("indirect address not taken from register");
    ext_fetch_a: assert property ((state == ST_DECODE && is_gen && op_mode == MODE_MEM)
        |=> state == ST_FETCH_EXT && mem_req && !mem_we && mem_addr == $past(ext_ptr))
        else $error("extension word not fetched");
    symbolic_ea_a: assert property ((state == ST_FETCH_EXT && mem_ack
        && op_reg == REG_ZERO)
        |=> state == ST_NEXT && cur_ea == $past(mem_rdata))
        else $error("symbolic address altered by index");
    indexed_ea_a: assert property ((reg_read_done_s and op_mode == MODE_MEM)
        |=> cur_ea == $past(mem_rdata) + ext)
        else $error("indexed address wrong");
    no_index_zero_a: assert property ((state == ST_READ_REG && op_mode == MODE_MEM)
        |-> op_reg != REG_ZERO)
        else $error("register zero used as index");
    autoinc_write_a: assert property ((reg_read_done_s and op_mode == MODE_AUTO)
        |=> state == ST_WRITE_REG && mem_we && mem_addr == $past(mem_addr)
            && mem_wdata == $past(mem_rdata) + (instr[POS_BYTE] ? STEP_BYTE : STEP_WORD))
        else $error("auto increment write back wrong");
    jump_target_a: assert property ((state == ST_DECODE && kind == KIND_JUMP)
        |=> done && !target[0]
            && target[15:1] == $past(pc[15:1]) + 15'h0001 + $past(disp_sext[14:0]))
        else $error("jump target wrong");
    io_addr_a: assert property ((state == ST_READ_IOBASE && mem_ack)
        |=> io_addr == $past(mem_rdata[12:1]) + disp_sext[11:0] ##1 io_write)
        else $error("io bit address wrong");
    io_value_a: assert property ((state == ST_IO_DRIVE)
        |=> io_write && io_bit == (kind == KIND_BIT_ONE) ##1 !io_write)
        else $error("io bit value wrong");
    ext_order_a: assert property ((state == ST_FETCH_EXT && mem_ack)
        |=> ext_ptr == $past(ext_ptr) + WORD_BYTES)
        else $error("extension pointer not advanced");
    reg_addr_a: assert property ((state == ST_READ_REG && mem_req)
        |-> mem_addr == wp + {11'h000, op_reg, 1'b0})
        else $error("register not at workspace plus 2n");
endmodule : oag_operand_address_generator
`default_nettype wire

// >>> bench/oag_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module oag_mem_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [3:0] lat,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [15:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    output logic [15:0] mem_rdata,
    output logic mem_ack
);
    logic [15:0] mem [0:511];
    logic [15:0] last;
    logic [3:0] cnt;
    // ack after lat wait cycles; read data is junk outside the ack cycle
    assign mem_ack = mem_req && (cnt == lat);
    assign mem_rdata = mem_ack ? mem[mem_addr[9:1]] : ~last;
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt <= 4'h0;
            last <= 16'h0000;
        end else if (mem_ack) begin
            cnt <= 4'h0;
            last <= mem_rdata;
            if (mem_we) begin
                mem[mem_addr[9:1]] <= mem_wdata;
            end
        end else if (mem_req) begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule : oag_mem_model
`default_nettype wire

// >>> bench/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
    import oag_pkg::*;
    localparam logic [15:0] WP = 16'h0100;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [OAG_AW-1:0] avs_address = 6'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, mem_req, mem_we, mem_ack, io_bit, io_write, io_b;
    logic [15:0] mem_addr, mem_wdata, mem_rdata;
    logic [11:0] io_addr, io_a;
    logic [3:0] lat = 4'h0;
    logic [15:0] rd_log[$];
    int errors = 0;
    int check_count = 0;
    int io_seen = 0;

    always #2 clk = ~clk;

    oag_operand_address_generator dut (.clk, .nrst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .mem_req, .mem_we, .mem_addr,
        .mem_wdata, .mem_rdata, .mem_ack, .io_addr, .io_bit, .io_write);
    oag_mem_model u_mem (.clk, .nrst, .lat, .mem_req, .mem_we, .mem_addr, .mem_wdata,
        .mem_rdata, .mem_ack);

    always @(posedge clk) begin
        if (io_write === 1'b1) begin
            io_seen++;
            io_a = io_addr;
            io_b = io_bit;
        end
        if (mem_req === 1'b1 && mem_ack === 1'b1 && mem_we === 1'b0) begin
            rd_log.push_back(mem_addr);
        end
    end

    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [OAG_AW-1:0] a, input logic [31:0] d,
                       output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 64);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            errors++;
            finish_test();
        end
    endtask : bus

    task automatic wr(input logic [OAG_AW-1:0] a, input logic [15:0] d);
        logic [31:0] x;
        bus(1'b1, a, {16'h0000, d}, x);
    endtask : wr

    task automatic rchk(input logic [OAG_AW-1:0] a, input logic [31:0] e);
        logic [31:0] x;
        bus(1'b0, a, 32'h0000_0000, x);
        chk(x, e);
    endtask : rchk

    task automatic setw(input logic [15:0] a, input logic [15:0] d);
        u_mem.mem[a[9:1]] = d;
    endtask : setw

    function automatic logic [15:0] mk(input logic b, input logic [1:0] td,
                                       input logic [3:0] d, input logic [1:0] ts,
                                       input logic [3:0] s);
        mk = {3'h0, b, td, d, ts, s};
    endfunction : mk

    task automatic run(input logic [2:0] k, input logic [15:0] ins, input logic [15:0] pc);
        logic [31:0] s;
        int n;
        n = 0;
        s = 32'h0000_0000;
        rd_log.delete();
        wr(OFS_WP, WP);
        wr(OFS_PC, pc);
        wr(OFS_INSTR, ins);
        wr(OFS_KIND, {13'h0000, k});
        wr(OFS_CTRL, 16'h0001);
        while (s[1:0] !== 2'b10 && n < 50) begin
            bus(1'b0, OFS_STATUS, 32'h0000_0000, s);
            n++;
        end
        if (s[1:0] !== 2'b10) begin
            errors++;
            finish_test();
        end
    endtask : run

    task automatic t_reset;
        logic [OAG_AW-1:0] offs[10];
        offs = '{OFS_CTRL, OFS_STATUS, OFS_INSTR, OFS_KIND, OFS_WP, OFS_PC, OFS_SRC_EA,
                 OFS_DST_EA, OFS_TARGET, OFS_IO_ADDR};
        foreach (offs[i]) begin
            rchk(offs[i], 32'h0000_0000);
        end
        wr(6'h28, 16'hffff);
        rchk(6'h28, 32'h0000_0000);
        $display("test reset done");
    endtask : t_reset

    task automatic t_sym;
        lat = 4'h3;
        setw(WP, 16'h7777);
        setw(WP + 16'h000a, 16'h0030);
        setw(16'h0202, 16'h1234);
        setw(16'h0204, 16'h0040);
        run(KIND_TWO, mk(1'b0, MODE_MEM, 4'h5, MODE_MEM, 4'h0), 16'h0200);
        rchk(OFS_SRC_EA, 32'h0000_1234);
        rchk(OFS_DST_EA, 32'h0000_0070);
        chk(32'(rd_log.size()), 32'h0000_0003);
        if (rd_log.size() == 3) begin
            chk({16'h0000, rd_log[0]}, 32'h0000_0202);
            chk({16'h0000, rd_log[1]}, 32'h0000_0204);
            chk({16'h0000, rd_log[2]}, {16'h0000, WP + 16'h000a});
        end
        $display("test symbolic and indexed done");
    endtask : t_sym

    task automatic t_ind;
        lat = 4'h0;
        setw(WP + 16'h000e, 16'h0456);
        run(KIND_TWO, mk(1'b0, MODE_IND, 4'h7, MODE_REG, 4'h4), 16'h0200);
        rchk(OFS_SRC_EA, {16'h0000, WP + 16'h0008});
        rchk(OFS_STATUS, 32'h0000_0006);
        rchk(OFS_DST_EA, 32'h0000_0456);
        $display("test register and indirect done");
    endtask : t_ind

    task automatic t_auto;
        for (int b = 0; b < 2; b++) begin
            lat = b[0] ? 4'h2 : 4'h0;
            setw(WP + 16'h0006, 16'h0300);
            run(KIND_ONE, mk(b[0], MODE_REG, 4'h0, MODE_AUTO, 4'h3), 16'h0200);
            rchk(OFS_SRC_EA, 32'h0000_0300);
            chk({16'h0000, u_mem.mem[(WP[9:1] + 9'h003)]},
                b[0] ? 32'h0000_0301 : 32'h0000_0302);
        end
        $display("test auto increment done");
    endtask : t_auto

    task automatic t_jump;
        logic [15:0] pcs[4];
        logic [7:0] ds[4];
        logic [15:0] e;
        pcs = '{16'h0200, 16'h0200, 16'h0201, 16'hfffe};
        ds = '{8'h80, 8'h7f, 8'h01, 8'hff};
        foreach (pcs[i]) begin
            e = (pcs[i] + 16'h0002 + {{7{ds[i][7]}}, ds[i], 1'b0}) & 16'hfffe;
            run(KIND_JUMP, {8'h10, ds[i]}, pcs[i]);
            rchk(OFS_TARGET, {16'h0000, e});
        end
        $display("test jump done");
    endtask : t_jump

    task automatic t_io;
        logic [15:0] r12[4];
        logic [7:0] ds[4];
        logic [11:0] e;
        int n0;
        r12 = '{16'h0020, 16'h0040, 16'he021, 16'h0020};
        ds = '{8'h08, 8'h0a, 8'h80, 8'h7f};
        foreach (r12[i]) begin
            e = r12[i][12:1] + {{4{ds[i][7]}}, ds[i]};
            setw(WP + 16'h0018, r12[i]);
            n0 = io_seen;
            run(i[0] ? KIND_BIT_ZERO : KIND_BIT_ONE, {8'h1d, ds[i]}, 16'h0200);
            chk(32'(io_seen - n0), 32'h0000_0001);
            chk({20'h0_0000, io_a}, {20'h0_0000, e});
            chk({31'h0000_0000, io_b}, {31'h0000_0000, !i[0]});
            rchk(OFS_IO_ADDR, {20'h0_0000, e});
        end
        $display("test serial bit done");
    endtask : t_io

    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_sym();
        t_ind();
        t_auto();
        t_jump();
        t_io();
        finish_test();
    end
endmodule : tb
`default_nettype wire
